//--- hdl/octal_flash_consts.vh
// constants for the octal flash command decoder
// assumes a 10 MHz system clock and a host-driven link clock
`ifndef OCTAL_FLASH_CONSTS_VH
`define OCTAL_FLASH_CONSTS_VH
`define OP_ENTER_4B      8'hB7
`define OP_EXIT_4B       8'hE9
`define OP_ENTER_DPD     8'hB9
`define OP_RELEASE_DPD   8'hAB
`define OP_RD_SECT_PROT  8'h2D
`define OP_PG_SECT_PROT  8'h2C
`define OP_RD_VLOCK      8'hE8
`define OP_WR_VLOCK      8'hE5
`define OP_RD_NVLOCK     8'hE2
`define OP_WR_NVLOCK     8'hE3
`define OP_ER_NVLOCK     8'hE4
`define OP_RD_FREEZE     8'hA7
`define OP_WR_FREEZE     8'hA6
`define OP_RD_PASSWORD   8'h27
`define OP_WR_PASSWORD   8'h28
`define OP_UNLOCK_PASS   8'h29
`define OP_RD_VLOCK_4B   8'hE0
`define OP_WR_VLOCK_4B   8'hE1
`define OP_TRAINING_RD   8'hCD
`define OP_RESET_ENABLE  8'h66
`define OP_RESET_MEMORY  8'h99
`define OP_READ_ID_A     8'h9E
`define OP_READ_ID_B     8'h9F
`define OP_READ_SFDP     8'h5A
`define OP_READ_FLAG     8'h70
`define FLAG_READY_BIT   7
`define DUMMY_OCTAL_FIX  8'h08
`define DUMMY_TRAIN_ADD  8'h02
`define DUMMY_OCTAL_RST  8'h10
`define TRAIN_PATTERN    8'h55
`define PASSWORD_RST     64'h0000000000000000
`define ID_BYTE0         8'h11
`define ID_BYTE1         8'h22
`define ID_BYTE2         8'h33
`endif

//--- hdl/link_sync.v
// two-flop synchroniser and edge finder for the host link pins
// assumes the link pins are asynchronous to clk_i
`default_nettype none
module link_sync (
   input  wire       clk_i,
   input  wire       rst_n,
   input  wire       sclk_i,
   input  wire       cs_n_i,
   output reg        cs_n,
   output reg        rise,
   output reg        fall
);
   reg       sclk_a;
   reg       sclk_b;
   reg       sclk_c;
   reg       cs_a;
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sclk_a <= 1'b0;
         sclk_b <= 1'b0;
         sclk_c <= 1'b0;
         cs_a   <= 1'b1;
         cs_n   <= 1'b1;
         rise   <= 1'b0;
         fall   <= 1'b0;
      end else begin
         sclk_a <= sclk_i;
         sclk_b <= sclk_a;
         sclk_c <= sclk_b;
         cs_a   <= cs_n_i;
         cs_n   <= cs_a;
         // edges only count while selected, so a parked clock is harmless
         rise   <= sclk_b & ~sclk_c & ~cs_n;
         fall   <= ~sclk_b & sclk_c & ~cs_n;
      end
   end
endmodule // link_sync
`default_nettype wire

//--- hdl/byte_shifter.v
// shifts bytes in on rising link edges, out on falling edges
// assumes one line in single mode, eight lines in octal mode
`default_nettype none
`include "octal_flash_consts.vh"
module byte_shifter (
   input  wire       clk_i,
   input  wire       rst_n,
   input  wire       clear_i,
   input  wire       octal_i,
   input  wire       rise_i,
   input  wire       fall_i,
   input  wire [7:0] lines_i,
   input  wire [7:0] tx_byte_i,
   output reg  [7:0] rx_byte_o,
   output reg        rx_done_o,
   output reg        tx_need_o,
   output reg  [7:0] lines_o
);
   reg [2:0] bit_cnt;
   reg [7:0] shift_in;
   reg [7:0] shift_out;
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt   <= 3'h0;
         shift_in  <= 8'h00;
         shift_out <= 8'h00;
         rx_byte_o <= 8'h00;
         rx_done_o <= 1'b0;
         tx_need_o <= 1'b0;
         lines_o   <= 8'h00;
      end else begin
         rx_done_o <= 1'b0;
         tx_need_o <= 1'b0;
         if (clear_i) begin
            bit_cnt <= 3'h0;
         end else if (rise_i) begin
            if (octal_i) begin
               rx_byte_o <= lines_i;
               rx_done_o <= 1'b1;
            end else begin
               shift_in <= {shift_in[6:0], lines_i[0]};
               bit_cnt  <= bit_cnt + 3'h1;
               if (bit_cnt == 3'h7) begin
                  rx_byte_o <= {shift_in[6:0], lines_i[0]};
                  rx_done_o <= 1'b1;
               end
            end
         end else if (fall_i) begin
            // msb first on the single line
            if (octal_i || bit_cnt == 3'h0) begin
               lines_o   <= octal_i ? tx_byte_i : {7'h00, tx_byte_i[7]};
               shift_out <= {tx_byte_i[6:0], 1'b0};
               tx_need_o <= 1'b1;
            end else begin
               lines_o   <= {7'h00, shift_out[7]};
               shift_out <= {shift_out[6:0], 1'b0};
            end
            if (!octal_i) begin
               bit_cnt <= bit_cnt + 3'h1;
            end
         end
      end
   end
endmodule // byte_shifter
`default_nettype wire

//--- hdl/octal_flash_cmd_decoder.v
// command decoder for an octal serial flash
// assumes host drives cs, clock and lines; array logic lives outside
// What this block does
// - discovery read takes three address bytes, four in octal ddr
// - variable-address commands use four bytes if four-byte mode or octal ddr
// - octal ddr forces four-byte addressing; enter/exit four-byte do nothing
// - password read sends 64 bits, low byte first, msb first per byte
// - password read repeats the 64-bit value while selected
// - training read dummy count is octal ddr dummy setting plus two
// - training read has no address, outputs on eight lines until deselect
// - deep power-down enter and release are bare opcodes
// - nonvolatile lock read takes four address bytes, 8 dummies in octal ddr
// - nonvolatile lock write takes four address bytes, no data
// - erase nonvolatile lock bits is a bare opcode
// - freeze read has no address, 8 dummies in octal; freeze set is bare
// - after reset-memory and cs high, device enters power-on reset
// - software reset clears volatile locks and restores config from nonvolatile
// - software reset aborts running or suspended write, program or erase
// - reset done once flag status bit 7 reads one
// - reset-enable ignored during status or nonvolatile-config write
// - id read during erase or program is not decoded
// - cs high returns to standby and ends an id read
`default_nettype none
`include "octal_flash_consts.vh"
module octal_flash_cmd_decoder (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        sclk_i,
   input  wire        cs_n_i,
   input  wire [7:0]  serial_lines_i,
   input  wire        octal_ddr_i,
   input  wire        cfg_4byte_i,
   input  wire [7:0]  cfg_ddr_dummy_i,
   input  wire        busy_erase_prog_i,
   input  wire        busy_reg_write_i,
   input  wire        suspended_i,
   input  wire [7:0]  nv_config_i,
   input  wire [63:0] password_i,
   input  wire [7:0]  lock_status_i,
   output reg  [7:0]  serial_lines_o,
   output reg  [7:0]  serial_lines_oe_o,
   output reg         addr_4byte_o,
   output reg         deep_power_down_o,
   output reg         freeze_o,
   output reg  [7:0]  volatile_config_o,
   output reg  [7:0]  volatile_lock_o,
   output reg         nvlock_write_o,
   output reg         nvlock_erase_o,
   output reg  [31:0] address_o,
   output reg         abort_op_o,
   output reg         reset_busy_o,
   output reg  [7:0]  last_opcode_o
);
////////////////////////////////////////////////////////////////////////
   localparam ST_OPCODE = 3'h0;
   localparam ST_ADDR   = 3'h1;
   localparam ST_DUMMY  = 3'h2;
   localparam ST_DATA   = 3'h3;
   localparam ST_IN     = 3'h4;
   localparam ST_IGNORE = 3'h5;
   localparam ST_DONE   = 3'h6;

   localparam SRC_NONE  = 3'h0;
   localparam SRC_PASS  = 3'h1;
   localparam SRC_TRAIN = 3'h2;
   localparam SRC_ID    = 3'h3;
   localparam SRC_LOCK  = 3'h4;
   localparam SRC_FRZ   = 3'h5;
   localparam SRC_FLAG  = 3'h6;

   // address bytes: 0 none, 3 or 4; variable ones follow mode
   function [2:0] addr_len;
      input [7:0] op;
      input       four;
      input       ddr;
      begin
         if (op == `OP_RD_NVLOCK || op == `OP_WR_NVLOCK ||
             op == `OP_RD_VLOCK_4B || op == `OP_WR_VLOCK_4B) begin
            addr_len = 3'h4;
         end else if (op == `OP_READ_SFDP) begin
            addr_len = ddr ? 3'h4 : 3'h3;
         end else if (op == `OP_RD_VLOCK || op == `OP_WR_VLOCK) begin
            addr_len = (four || ddr) ? 3'h4 : 3'h3;
         end else begin
            addr_len = 3'h0;
         end
      end
   endfunction

////////////////////////////////////////////////////////////////////////
   reg        rst_a;
   reg        rst_n;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_a <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_a <= 1'b1;
         rst_n <= rst_a;
      end
   end

   wire       cs_n;
   wire       rise;
   wire       fall;
   link_sync u_sync (
      .clk_i  (clk_i),
      .rst_n  (rst_n),
      .sclk_i (sclk_i),
      .cs_n_i (cs_n_i),
      .cs_n   (cs_n),
      .rise   (rise),
      .fall   (fall)
   );

   reg  [7:0] lines_s1;
   reg  [7:0] lines_s2;
   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         lines_s1 <= 8'h00;
         lines_s2 <= 8'h00;
      end else begin
         lines_s1 <= serial_lines_i;
         lines_s2 <= lines_s1;
      end
   end

   reg  [2:0] state;
   reg  [2:0] src;
   reg  [7:0] opcode;
   reg  [2:0] addr_left;
   reg  [7:0] dummy_left;
   reg  [2:0] tx_index;
   reg  [7:0] tx_byte;
   reg        out_octal;
   reg        reset_armed;
   reg        cs_prev;
   reg  [1:0] id_index;

   wire       rx_octal = octal_ddr_i;
   wire [7:0] rx_byte;
   wire       rx_done;
   wire       tx_need;
   wire [7:0] shift_lines;
   byte_shifter u_shift (
      .clk_i     (clk_i),
      .rst_n     (rst_n),
      .clear_i   (cs_n),
      .octal_i   ((state == ST_DATA) ? out_octal : rx_octal),
      .rise_i    (rise & (state != ST_DATA)),
      .fall_i    (fall & (state == ST_DATA)),
      .lines_i   (lines_s2),
      .tx_byte_i (tx_byte),
      .rx_byte_o (rx_byte),
      .rx_done_o (rx_done),
      .tx_need_o (tx_need),
      .lines_o   (shift_lines)
   );

////////////////////////////////////////////////////////////////////////
   // next output byte from the selected source
   always @* begin
      case (src)
         SRC_PASS:  tx_byte = password_i[{tx_index, 3'h0} +: 8];
         SRC_TRAIN: tx_byte = `TRAIN_PATTERN;
         SRC_ID:    tx_byte = (id_index == 2'h0) ? `ID_BYTE0 :
                              (id_index == 2'h1) ? `ID_BYTE1 : `ID_BYTE2;
         SRC_LOCK:  tx_byte = lock_status_i;
         SRC_FRZ:   tx_byte = {7'h00, freeze_o};
         SRC_FLAG:  tx_byte = {~reset_busy_o, 7'h00};
         default:   tx_byte = 8'h00;
      endcase
   end

   wire        sel_fall = cs_n & ~cs_prev;

   always @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state             <= ST_OPCODE;
         src               <= SRC_NONE;
         opcode            <= 8'h00;
         addr_left         <= 3'h0;
         dummy_left        <= 8'h00;
         tx_index          <= 3'h0;
         id_index          <= 2'h0;
         out_octal         <= 1'b0;
         reset_armed       <= 1'b0;
         cs_prev           <= 1'b1;
         serial_lines_o    <= 8'h00;
         serial_lines_oe_o <= 8'h00;
         addr_4byte_o      <= 1'b0;
         deep_power_down_o <= 1'b0;
         freeze_o          <= 1'b0;
         volatile_config_o <= 8'h00;
         volatile_lock_o   <= 8'h00;
         nvlock_write_o    <= 1'b0;
         nvlock_erase_o    <= 1'b0;
         address_o         <= 32'h00000000;
         abort_op_o        <= 1'b0;
         reset_busy_o      <= 1'b1;
         last_opcode_o     <= 8'h00;
      end else begin
         cs_prev        <= cs_n;
         nvlock_write_o <= 1'b0;
         nvlock_erase_o <= 1'b0;
         abort_op_o     <= 1'b0;
         reset_busy_o   <= 1'b0;
         if (octal_ddr_i) begin
            addr_4byte_o <= 1'b1;
         end
         if (cs_n) begin
            serial_lines_oe_o <= 8'h00;
            src               <= SRC_NONE;
            state             <= ST_OPCODE;
            if (sel_fall) begin
               // actions take effect on deselect
               if (state == ST_DONE || state == ST_IN) begin
                  case (opcode)
                     `OP_ENTER_4B:    if (!octal_ddr_i) addr_4byte_o <= 1'b1;
                     `OP_EXIT_4B:     if (!octal_ddr_i) addr_4byte_o <= 1'b0;
                     `OP_ENTER_DPD:   deep_power_down_o <= 1'b1;
                     `OP_RELEASE_DPD: deep_power_down_o <= 1'b0;
                     `OP_WR_NVLOCK:   nvlock_write_o    <= 1'b1;
                     `OP_ER_NVLOCK:   nvlock_erase_o    <= 1'b1;
                     `OP_WR_FREEZE:   freeze_o          <= 1'b1;
                     default: ;
                  endcase
                  // enable only arms if no register write runs
                  if (opcode == `OP_RESET_ENABLE) begin
                     reset_armed <= ~busy_reg_write_i;
                  end else if (opcode == `OP_RESET_MEMORY && reset_armed) begin
                     // relied upon: the enable came in an earlier frame
                     reset_armed       <= 1'b0;
                     reset_busy_o      <= 1'b1;
                     volatile_config_o <= nv_config_i;
                     volatile_lock_o   <= 8'h00;
                     freeze_o          <= 1'b0;
                     addr_4byte_o      <= octal_ddr_i | cfg_4byte_i;
                     deep_power_down_o <= 1'b0;
                     abort_op_o        <= busy_erase_prog_i | suspended_i;
                  end else begin
                     reset_armed <= 1'b0;
                  end
               end
            end
         end else begin
            case (state)
               ST_OPCODE: begin
                  if (rx_done) begin
                     opcode        <= rx_byte;
                     last_opcode_o <= rx_byte;
                     tx_index      <= 3'h0;
                     id_index      <= 2'h0;
                     addr_left     <= addr_len(rx_byte, addr_4byte_o | cfg_4byte_i, octal_ddr_i);
                     if (deep_power_down_o && rx_byte != `OP_RELEASE_DPD) begin
                        state <= ST_IGNORE;
                     end else if ((rx_byte == `OP_READ_ID_A || rx_byte == `OP_READ_ID_B) &&
                                  busy_erase_prog_i) begin
                        state <= ST_IGNORE;
                     end else if (addr_len(rx_byte, addr_4byte_o | cfg_4byte_i, octal_ddr_i) != 3'h0) begin
                        state <= ST_ADDR;
                     end else begin
                        case (rx_byte)
                           `OP_ENTER_4B, `OP_EXIT_4B, `OP_ENTER_DPD, `OP_RELEASE_DPD,
                           `OP_ER_NVLOCK, `OP_WR_FREEZE, `OP_RESET_ENABLE,
                           `OP_RESET_MEMORY: state <= ST_DONE;
                           `OP_PG_SECT_PROT, `OP_WR_PASSWORD,
                           `OP_UNLOCK_PASS: state <= ST_IN;
                           `OP_TRAINING_RD: begin
                              src        <= SRC_TRAIN;
                              out_octal  <= 1'b1;
                              dummy_left <= cfg_ddr_dummy_i + `DUMMY_TRAIN_ADD;
                              state      <= ST_DUMMY;
                           end
                           `OP_RD_PASSWORD, `OP_RD_FREEZE, `OP_RD_SECT_PROT: begin
                              src        <= (rx_byte == `OP_RD_PASSWORD) ? SRC_PASS :
                                            (rx_byte == `OP_RD_FREEZE) ? SRC_FRZ : SRC_LOCK;
                              out_octal  <= octal_ddr_i;
                              dummy_left <= octal_ddr_i ? `DUMMY_OCTAL_FIX : 8'h00;
                              state      <= ST_DUMMY;
                           end
                           `OP_READ_ID_A, `OP_READ_ID_B, `OP_READ_FLAG: begin
                              src        <= (rx_byte == `OP_READ_FLAG) ? SRC_FLAG : SRC_ID;
                              out_octal  <= octal_ddr_i;
                              dummy_left <= octal_ddr_i ? `DUMMY_OCTAL_FIX : 8'h00;
                              state      <= ST_DUMMY;
                           end
                           default: state <= ST_IGNORE;
                        endcase
                     end
                  end
               end
               ST_ADDR: begin
                  if (rx_done) begin
                     address_o <= {address_o[23:0], rx_byte};
                     addr_left <= addr_left - 3'h1;
                     if (addr_left == 3'h1) begin
                        if (opcode == `OP_WR_NVLOCK || opcode == `OP_WR_VLOCK ||
                            opcode == `OP_WR_VLOCK_4B) begin
                           state <= ST_IN;
                        end else begin
                           src        <= SRC_LOCK;
                           out_octal  <= octal_ddr_i;
                           dummy_left <= octal_ddr_i ? `DUMMY_OCTAL_FIX : 8'h00;
                           state      <= ST_DUMMY;
                        end
                     end
                  end
               end
               ST_DUMMY: begin
                  if (dummy_left == 8'h00) begin
                     state <= ST_DATA;
                  end else if (rise) begin
                     dummy_left <= dummy_left - 8'h01;
                  end
               end
               ST_DATA: begin
                  serial_lines_oe_o <= out_octal ? 8'hFF : 8'h01;
                  serial_lines_o    <= shift_lines;
                  if (tx_need) begin
                     tx_index <= tx_index + 3'h1;
                     if (id_index != 2'h2) begin
                        id_index <= id_index + 2'h1;
                     end
                  end
               end
               ST_IN: begin
                  if (rx_done && opcode == `OP_WR_VLOCK) begin
                     volatile_lock_o <= rx_byte;
                  end
               end
               default: ;
            endcase
         end
      end
   end
endmodule // octal_flash_cmd_decoder
`default_nettype wire

//--- tb/octal_flash_cmd_decoder_assertions.sv
// checker for the octal flash command decoder
// assumes bind to the decoder top; one clock domain, async low reset
`default_nettype none
module octal_flash_cmd_decoder_checker (
   input wire logic       clk_i,
   input wire logic       rst_n_i,
   input wire logic       cs_n_i,
   input wire logic       octal_ddr_i,
   input wire logic [7:0] serial_lines_oe_o,
   input wire logic       addr_4byte_o,
   input wire logic       deep_power_down_o,
   input wire logic       freeze_o,
   input wire logic       nvlock_write_o,
   input wire logic       nvlock_erase_o,
   input wire logic       abort_op_o,
   input wire logic       reset_busy_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////
   // eight idle cycles cover the two-flop sync plus edge detect
   sequence s_idle;
      cs_n_i [*8];
   endsequence
   sequence s_oct4;
      octal_ddr_i && addr_4byte_o ##1 octal_ddr_i;
   endsequence
   a_oe_idle_off: assert property (s_idle |-> serial_lines_oe_o == 8'h00)
      else $error("lines driven while deselected");
   a_oe_lane_width: assert property (serial_lines_oe_o inside {8'h00, 8'h01, 8'hFF})
      else $error("odd output enable pattern");
   a_dpd_enter_idle: assert property ($rose(deep_power_down_o) |-> cs_n_i && $past(cs_n_i, 2))
      else $error("power-down entered inside a frame");
   a_dpd_exit_idle: assert property ($fell(deep_power_down_o) |-> cs_n_i)
      else $error("power-down left inside a frame");
   a_nvw_one_pulse: assert property (nvlock_write_o |-> cs_n_i ##1 !nvlock_write_o)
      else $error("lock write pulse wrong");
   a_nve_one_pulse: assert property (nvlock_erase_o |-> cs_n_i ##1 !nvlock_erase_o)
      else $error("lock erase pulse wrong");
   a_abort_on_idle: assert property (abort_op_o |-> cs_n_i ##1 !abort_op_o)
      else $error("abort pulse wrong");
   a_freeze_set_idle: assert property ($rose(freeze_o) |-> cs_n_i)
      else $error("freeze set inside a frame");
   a_octal_keeps_4b: assert property (s_oct4 |-> addr_4byte_o)
      else $error("four-byte mode lost in octal");
   a_rbusy_one_pulse: assert property ($rose(reset_busy_o) |-> cs_n_i ##1 !reset_busy_o)
      else $error("reset busy pulse wrong");
endmodule  // octal_flash_cmd_decoder_checker
bind octal_flash_cmd_decoder octal_flash_cmd_decoder_checker i_checker (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .octal_ddr_i(octal_ddr_i),
   .serial_lines_oe_o(serial_lines_oe_o), .addr_4byte_o(addr_4byte_o),
   .deep_power_down_o(deep_power_down_o), .freeze_o(freeze_o),
   .nvlock_write_o(nvlock_write_o), .nvlock_erase_o(nvlock_erase_o),
   .abort_op_o(abort_op_o), .reset_busy_o(reset_busy_o));
`default_nettype wire

//--- tb/host_link_model.sv
// host controller model: chip select, link clock, line bytes
// assumes a 100 ns bench clock; link clock is 800 ns, idle low
`default_nettype none
module host_link_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] dev_lines_i,
   input  wire logic [7:0] dev_oe_i,
   output var  logic       cs_n_o,
   output var  logic       sclk_o,
   output wire logic [7:0] lines_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] drv = 8'h00;
   logic       drv_en = 1'b0;
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
   end
   ////////////////////////////////////////
   // released lines show the inverse, so a stale value never passes
   assign lines_o = (dev_oe_i & dev_lines_i) | (~dev_oe_i & (drv_en ? drv : ~drv));
   task automatic half(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic start;
      half(1);
      cs_n_o = 1'b0;
      half(4);
   endtask
   task automatic clocks(input int n);
      repeat (n) begin
         half(4);
         sclk_o = 1'b1;
         half(4);
         sclk_o = 1'b0;
      end
   endtask
   // caller sends as many address bytes as the mode asks
   task automatic put(input logic [7:0] b, input logic oct);
      drv_en = 1'b1;
      for (int i = oct ? 0 : 7; i >= 0; i--) begin
         drv = oct ? b : {7'h00, b[i]};
         clocks(1);
      end
      drv_en = 1'b0;
   endtask
   task automatic get(output logic [7:0] b, input logic oct);
      for (int i = oct ? 0 : 7; i >= 0; i--) begin
         half(4);
         sclk_o = 1'b1;
         half(3);
         if (oct) b = lines_o;
         else b[i] = lines_o[0];
         half(1);
         sclk_o = 1'b0;
      end
   endtask
   // long gap doubles as the deselect gap of the reset pair;
   // the host never runs execute-in-place here
   task automatic stop;
      half(2);
      cs_n_o = 1'b1;
      half(12);
   endtask
endmodule  // host_link_model
`default_nettype wire

//--- tb/octal_flash_cmd_decoder_test.sv
// testbench for the octal flash command decoder
// assumes the host model and the bound checker are compiled first
`default_nettype none
`include "octal_flash_consts.vh"
module octal_flash_cmd_decoder_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        oct = 1'b0;
   logic        busy_ep = 1'b0;
   logic        busy_rw = 1'b0;
   logic [7:0]  dummy = 8'h10;
   logic [63:0] pass = 64'h0123456789ABCDEF;
   logic [39:0] addr_pat = 40'h0012345678;
   logic        cs_n, sclk, a4, dpd, frz, nvw, nve, abrt, rbusy;
   logic [7:0]  lines, d_out, d_oe, vcfg, vlock, last_op, b;
   logic [31:0] addr;
   int          errors = 0, check_count = 0, n_nvw = 0, n_nve = 0, n_abrt = 0;
   octal_flash_cmd_decoder i_octal_flash_cmd_decoder (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .serial_lines_i(lines), .octal_ddr_i(oct), .cfg_4byte_i(1'b0),
      .cfg_ddr_dummy_i(dummy), .busy_erase_prog_i(busy_ep), .busy_reg_write_i(busy_rw),
      .suspended_i(1'b0), .nv_config_i(8'hA5), .password_i(pass), .lock_status_i(8'h3C),
      .serial_lines_o(d_out), .serial_lines_oe_o(d_oe), .addr_4byte_o(a4),
      .deep_power_down_o(dpd), .freeze_o(frz), .volatile_config_o(vcfg),
      .volatile_lock_o(vlock), .nvlock_write_o(nvw), .nvlock_erase_o(nve),
      .address_o(addr), .abort_op_o(abrt), .reset_busy_o(rbusy), .last_opcode_o(last_op));
   host_link_model i_host_link_model (
      .clk_i(clk_i), .dev_lines_i(d_out), .dev_oe_i(d_oe),
      .cs_n_o(cs_n), .sclk_o(sclk), .lines_o(lines));
   initial forever #50 clk_i = ~clk_i;
   // one-cycle pulses are counted, not sampled
   always @(posedge clk_i) begin
      n_nvw += nvw;
      n_nve += nve;
      n_abrt += abrt;
   end
   ////////////////////////////////////////
   task automatic chk(input string what, input logic [63:0] exp, got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic cmd(input logic [7:0] op, input int n = 0);
      i_host_link_model.start();
      i_host_link_model.put(op, oct);
      for (int i = n - 1; i >= 0; i--) i_host_link_model.put(addr_pat[8*i+:8], oct);
      i_host_link_model.stop();
   endtask
   task automatic t_power;
      cmd(8'h3A, 1);
      chk("dpd after unknown", 0, dpd);
      cmd(8'hB9);
      chk("dpd on", 1, dpd);
      cmd(8'hAB);
      chk("dpd off", 0, dpd);
      chk("last op", 8'hAB, last_op);
      $display("test power done");
   endtask
   task automatic t_addr;
      cmd(8'hB7);
      chk("4b on", 1, a4);
      cmd(8'hE9);
      chk("4b off", 0, a4);
      oct = 1'b1;
      cmd(8'hE9);
      chk("4b octal", 1, a4);
      oct = 1'b0;
      $display("test addr done");
   endtask
   task automatic t_locks;
      cmd(8'hE3, 4);
      chk("nv write", 1, n_nvw);
      chk("nv addr", 32'h12345678, addr);
      cmd(8'hE4);
      chk("nv erase", 1, n_nve);
      cmd(8'hA6);
      chk("freeze", 1, frz);
      i_host_link_model.start();
      i_host_link_model.put(8'hE2, 1'b0);
      for (int i = 3; i >= 0; i--) i_host_link_model.put(addr_pat[8*i+:8], 1'b0);
      i_host_link_model.get(b, 1'b0);
      i_host_link_model.stop();
      chk("nv read", 8'h3C, b);
      $display("test locks done");
   endtask
   task automatic t_pass;
      i_host_link_model.start();
      i_host_link_model.put(8'h27, 1'b0);
      for (int i = 0; i < 9; i++) begin
         i_host_link_model.get(b, 1'b0);
         chk("pw byte", pass[8*(i%8)+:8], b);
      end
      i_host_link_model.stop();
      $display("test password done");
   endtask
   task automatic t_train;
      dummy = 8'h04;
      for (int m = 0; m < 2; m++) begin
         oct = m[0];
         i_host_link_model.start();
         i_host_link_model.put(8'hCD, oct);
         i_host_link_model.clocks(6);
         repeat (2) begin
            i_host_link_model.get(b, 1'b1);
            chk("train byte", `TRAIN_PATTERN, b);
         end
         chk("train lanes", 8'hFF, d_oe);
         i_host_link_model.stop();
      end
      oct = 1'b0;
      $display("test training done");
   endtask
   task automatic t_id;
      for (int m = 0; m < 2; m++) begin
         busy_ep = m[0];
         i_host_link_model.start();
         i_host_link_model.put(8'h9F, 1'b0);
         i_host_link_model.get(b, 1'b0);
         chk("id lanes", m ? 8'h00 : 8'h01, d_oe);
         if (m == 0) chk("id byte", `ID_BYTE0, b);
         i_host_link_model.stop();
         chk("id released", 8'h00, d_oe);
      end
      $display("test id done");
   endtask
   task automatic t_reset;
      cmd(8'hE5, 5);
      chk("vlock write", 8'h78, vlock);
      busy_rw = 1'b1;
      cmd(8'h66);
      busy_rw = 1'b0;
      cmd(8'h99);
      chk("reset refused", 0, n_abrt);
      cmd(8'h66);
      cmd(8'h99);
      chk("abort", 1, n_abrt);
      chk("vcfg default", 8'hA5, vcfg);
      chk("vlock default", 8'h00, vlock);
      busy_ep = 1'b0;
      b = 8'h00;
      for (int i = 0; i < 8 && b[7] !== 1'b1; i++) begin
         i_host_link_model.start();
         i_host_link_model.put(8'h70, 1'b0);
         i_host_link_model.get(b, 1'b0);
         i_host_link_model.stop();
      end
      chk("flag ready", 1, b[7]);
      $display("test reset done");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #3ms;
      errors++;
      finish_test;
   end
   initial begin
      repeat (16) @(negedge clk_i);
      rst_n_i = 1'b1;
      repeat (8) @(negedge clk_i);
      t_power;
      t_addr;
      t_locks;
      t_pass;
      t_train;
      t_id;
      busy_ep = 1'b1;
      t_reset;
      finish_test;
   end
endmodule  // octal_flash_cmd_decoder_test
`default_nettype wire
